// *** core/acqrs_top.sv ***
// Result, status and current path control registers behind the 4-wire serial port
`timescale 1ns/10ps
module acqrs_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	input wire logic [15:0] cur_result,
	input wire logic cur_valid,
	input wire logic [15:0] volt_result,
	input wire logic volt_valid,
	input wire logic normal_measure_mode_one_ready,
	input wire logic normal_measure_mode_two_thresh,
	input wire logic standby_measure_mode_one_ready,
	input wire logic standby_measure_mode_two_thresh,
	input wire logic analog_power_on_reset_flag,
	input wire logic oversampling_tick,
	output logic decim_rate_128,
	output logic [1:0] chop_div_sel,
	output logic [3:0] cic2_ratio_code,
	output logic [15:0] cic2_ratio,
	output logic sat_int_mask,
	output logic chopper_clock
);
	////////////////////////////////////////////////////////////////////////////////
	logic [2:0] pins_s;
	logic cs_n_s;
	logic sclk_s;
	logic mosi_s;
	logic sclk_prev_q;
	logic idle_pol_q;
	logic samp_edge;
	logic xfer_edge;
	logic [2:0] bitcnt_q;
	logic cmd_done_q;
	logic rw_q;
	logic [4:0] addr_q;
	logic [7:0] rx_q;
	logic [7:0] rx_byte;
	logic [7:0] tx_q;
	logic miso_q;
	logic byte_done;
	logic fetch_en;
	logic [4:0] fetch_addr;
	logic [7:0] fetch_data;
	logic wr_en;
	logic [15:0] cur_q;
	logic [15:0] volt_q;
	logic [7:0] status_q;
	logic [7:0] status_set;
	logic [7:0] status_clr;
	logic [7:0] ctrl_q;
	logic [7:0] shadow_i_q;
	logic [7:0] shadow_v_q;
	logic shad_i_vld_q;
	logic shad_v_vld_q;
	logic [9:0] chop_cnt_q;
	logic [9:0] chop_half;
	logic chop_q;
	logic [15:0] cic2_ratio_q;

	acqrs_pin_sync #(.W(3), .RST_VAL(acqrs_pkg::PIN_SYNC_RST)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({spi_cs_n, spi_sclk, spi_mosi}),
		.pin_out(pins_s)
	);
	assign cs_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign mosi_s = pins_s[0];

	////////////////////////////////////////////////////////////////////////////////
	// Idle level of sclk at the select edge fixes which edge samples and which shifts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclk_prev_q <= 1'b0;
			idle_pol_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			if (cs_n_s) begin
				idle_pol_q <= sclk_s;
			end
		end
	end

	assign samp_edge = ~cs_n_s & (sclk_s == idle_pol_q) & (sclk_prev_q != idle_pol_q);
	assign xfer_edge = ~cs_n_s & (sclk_s != idle_pol_q) & (sclk_prev_q == idle_pol_q);
	assign rx_byte = {rx_q[6:0], mosi_s};
	assign byte_done = samp_edge & (bitcnt_q == 3'h7);
	assign fetch_en = byte_done & (cmd_done_q ? rw_q : rx_byte[acqrs_pkg::CMD_READ_BIT]);
	assign fetch_addr = cmd_done_q ? 5'(addr_q + 5'h01) : rx_byte[4:0];
	assign wr_en = byte_done & cmd_done_q & ~rw_q;

	////////////////////////////////////////////////////////////////////////////////
	// Frame decode: command byte, then one data byte per address
	always_ff @(posedge clk) begin
		if (sys_rst || cs_n_s) begin
			bitcnt_q <= 3'h0;
			cmd_done_q <= 1'b0;
			rw_q <= 1'b0;
			addr_q <= 5'h00;
			rx_q <= 8'h00;
		end else if (samp_edge) begin
			bitcnt_q <= 3'(bitcnt_q + 3'h1);
			rx_q <= rx_byte;
			if (byte_done) begin
				cmd_done_q <= 1'b1;
				addr_q <= fetch_addr;
				if (!cmd_done_q) begin
					rw_q <= rx_byte[acqrs_pkg::CMD_READ_BIT];
				end
			end
		end
	end

	always_comb begin
		case (fetch_addr)
			acqrs_pkg::OFS_CUR_HI: fetch_data = cur_q[15:8];
			acqrs_pkg::OFS_CUR_LO: fetch_data = shad_i_vld_q ? shadow_i_q : cur_q[7:0];
			acqrs_pkg::OFS_VOLT_HI: fetch_data = volt_q[15:8];
			acqrs_pkg::OFS_VOLT_LO: fetch_data = shad_v_vld_q ? shadow_v_q : volt_q[7:0];
			acqrs_pkg::OFS_STATUS: fetch_data = status_q;
			acqrs_pkg::OFS_CUR_CTRL: fetch_data = ctrl_q;
			default: fetch_data = 8'h00;
		endcase
	end

	// Read data leaves on the edge that moves away from the idle level
	always_ff @(posedge clk) begin
		if (sys_rst || cs_n_s) begin
			tx_q <= 8'h00;
			miso_q <= 1'b0;
		end else if (fetch_en) begin
			tx_q <= fetch_data;
		end else if (xfer_edge && cmd_done_q && rw_q) begin
			miso_q <= tx_q[7];
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign spi_miso_o = miso_q;
	assign spi_miso_oe = ~cs_n_s & cmd_done_q & rw_q;

	////////////////////////////////////////////////////////////////////////////////
	// Snapshot of the low bytes taken when the high byte is fetched, dropped at frame end
	always_ff @(posedge clk) begin
		if (sys_rst || cs_n_s) begin
			shadow_i_q <= 8'h00;
			shadow_v_q <= 8'h00;
			shad_i_vld_q <= 1'b0;
			shad_v_vld_q <= 1'b0;
		end else if (fetch_en) begin
			if (fetch_addr == acqrs_pkg::OFS_CUR_HI) begin
				shadow_i_q <= cur_q[7:0];
				shad_i_vld_q <= 1'b1;
			end
			if (fetch_addr == acqrs_pkg::OFS_VOLT_HI) begin
				shadow_v_q <= volt_q[7:0];
				shad_v_vld_q <= 1'b1;
			end
		end
	end

	// Result registers are read-only from the port; conversions load them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_q <= acqrs_pkg::RES_RST;
			volt_q <= acqrs_pkg::RES_RST;
		end else begin
			if (cur_valid) begin
				cur_q <= cur_result;
			end
			if (volt_valid) begin
				volt_q <= volt_result;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags are sticky, cleared by fetching the status byte; a new event wins
	always_comb begin
		status_set = 8'h00;
		status_set[acqrs_pkg::ST_NOM_READY] = normal_measure_mode_one_ready;
		status_set[acqrs_pkg::ST_NORMAL_MEASURE_MODE_TWO_THRESH] = normal_measure_mode_two_thresh;
		status_set[acqrs_pkg::ST_STANDBY_MEASURE_MODE_ONE_READY] = standby_measure_mode_one_ready;
		status_set[acqrs_pkg::ST_STANDBY_MEASURE_MODE_TWO_THRESH] = standby_measure_mode_two_thresh;
		status_set[acqrs_pkg::ST_ANALOG_POWER_ON_RESET_FLAG] = analog_power_on_reset_flag;
		status_set[acqrs_pkg::ST_CUR_NEW] = cur_valid;
		status_set[acqrs_pkg::ST_VOLT_NEW] = volt_valid;
		status_clr = (fetch_en && fetch_addr == acqrs_pkg::OFS_STATUS) ? 8'hff : 8'h00;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q <= acqrs_pkg::STATUS_RST;
		end else begin
			status_q <= ((status_q & ~status_clr) | status_set) & 8'hfe;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= acqrs_pkg::CUR_CTRL_RST;
		end else if (wr_en && addr_q == acqrs_pkg::OFS_CUR_CTRL) begin
			ctrl_q <= rx_byte;
		end
	end

	assign decim_rate_128 = ctrl_q[acqrs_pkg::CTRL_DECIM_BIT];
	assign chop_div_sel = ctrl_q[acqrs_pkg::CTRL_CHOP_MSB:acqrs_pkg::CTRL_CHOP_LSB];
	assign cic2_ratio_code = ctrl_q[acqrs_pkg::CTRL_CIC2_MSB:acqrs_pkg::CTRL_CIC2_LSB];
	assign sat_int_mask = ctrl_q[acqrs_pkg::CTRL_SAT_MASK_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Chopper divider counts oversampling ticks and toggles every half period
	always_comb begin
		case (chop_div_sel)
			2'h1: chop_half = acqrs_pkg::CHOP_HALF_DIV256;
			2'h2: chop_half = acqrs_pkg::CHOP_HALF_DIV512;
			default: chop_half = acqrs_pkg::CHOP_HALF_DIV1024;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst || chop_div_sel == acqrs_pkg::CHOP_ALWAYS_HIGH) begin
			chop_cnt_q <= 10'h000;
			chop_q <= 1'b1;
		end else if (oversampling_tick) begin
			if (chop_cnt_q >= 10'(chop_half - 10'h001)) begin
				chop_cnt_q <= 10'h000;
				chop_q <= ~chop_q;
			end else begin
				chop_cnt_q <= 10'(chop_cnt_q + 10'h001);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cic2_ratio_q <= acqrs_pkg::CIC2_RATIO_RST;
		end else begin
			cic2_ratio_q <= 16'(16'h0001 << cic2_ratio_code);
		end
	end

	assign chopper_clock = chop_q;
	assign cic2_ratio = cic2_ratio_q;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking

	a_ctrl_reset_val: assert property (sys_rst |=> ctrl_q == 8'h45)
		else $error("control register reset value wrong");
	a_status_reset_zero: assert property (sys_rst |=> status_q == 8'h00)
		else $error("status not cleared by reset");
	a_status_rsvd_bit: assert property (disable iff (sys_rst) status_q[0] == 1'b0)
		else $error("reserved status bit set");
	a_cur_new_flag: assert property (disable iff (sys_rst)
		cur_valid |=> status_q[2] && cur_q == $past(cur_result))
		else $error("current update not flagged or not loaded");
	a_volt_new_flag: assert property (disable iff (sys_rst)
		volt_valid |=> status_q[1] && volt_q == $past(volt_result))
		else $error("voltage update not flagged or not loaded");
	a_ro_result_hold: assert property (disable iff (sys_rst)
		wr_en && addr_q < acqrs_pkg::OFS_CUR_CTRL && !cur_valid && !volt_valid
		|=> cur_q == $past(cur_q) && volt_q == $past(volt_q))
		else $error("result register changed by a write");
	a_ctrl_write_lands: assert property (disable iff (sys_rst)
		wr_en && addr_q == 5'h05 |=> ctrl_q == $past(rx_byte) && decim_rate_128 == ctrl_q[7])
		else $error("control write lost");
	a_addr_step: assert property (disable iff (sys_rst)
		byte_done && cmd_done_q && !cs_n_s |=> addr_q == 5'($past(addr_q) + 5'h01))
		else $error("address did not increment");
	a_low_byte_held: assert property (disable iff (sys_rst)
		fetch_en && fetch_addr == 5'h01 && shad_i_vld_q |=> tx_q == $past(shadow_i_q))
		else $error("low byte not taken from snapshot");
	a_chop_static_high: assert property (disable iff (sys_rst)
		chop_div_sel == 2'h0 |=> chopper_clock)
		else $error("chopper clock not held high");
	a_cic2_decode: assert property (disable iff (sys_rst)
		cic2_ratio_code == 4'h2 ##1 cic2_ratio_code == 4'h2 |-> cic2_ratio == 16'h0004)
		else $error("second stage ratio decode wrong");
endmodule : acqrs_top

// *** core/acqrs_pkg.sv ***
// Package with the register map, field layout and reset values of the result and status bank
package acqrs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int RES_W = 16;

	// Register offsets
	localparam logic [4:0] OFS_CUR_HI = 5'h00;
	localparam logic [4:0] OFS_CUR_LO = 5'h01;
	localparam logic [4:0] OFS_VOLT_HI = 5'h02;
	localparam logic [4:0] OFS_VOLT_LO = 5'h03;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_CUR_CTRL = 5'h05;

	// Reset values
	localparam logic [15:0] RES_RST = 16'h0000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CUR_CTRL_RST = 8'h45;
	localparam logic [15:0] CIC2_RATIO_RST = 16'h0004;

	// Status bit positions
	localparam int ST_NOM_READY = 7;
	localparam int ST_NORMAL_MEASURE_MODE_TWO_THRESH = 6;
	localparam int ST_STANDBY_MEASURE_MODE_ONE_READY = 5;
	localparam int ST_STANDBY_MEASURE_MODE_TWO_THRESH = 4;
	localparam int ST_ANALOG_POWER_ON_RESET_FLAG = 3;
	localparam int ST_CUR_NEW = 2;
	localparam int ST_VOLT_NEW = 1;
	localparam int ST_RSVD = 0;

	// Current path control fields
	localparam int CTRL_DECIM_BIT = 7;
	localparam int CTRL_CHOP_MSB = 6;
	localparam int CTRL_CHOP_LSB = 5;
	localparam int CTRL_CIC2_MSB = 4;
	localparam int CTRL_CIC2_LSB = 1;
	localparam int CTRL_SAT_MASK_BIT = 0;

	// Command byte fields
	localparam int CMD_READ_BIT = 7;

	// Chopper divider: half periods in oversampling ticks
	localparam logic [1:0] CHOP_ALWAYS_HIGH = 2'h0;
	localparam logic [9:0] CHOP_HALF_DIV256 = 10'h080;
	localparam logic [9:0] CHOP_HALF_DIV512 = 10'h100;
	localparam logic [9:0] CHOP_HALF_DIV1024 = 10'h200;

	// Pin synchroniser reset levels {cs_n, sclk, mosi}
	localparam logic [2:0] PIN_SYNC_RST = 3'h4;
endpackage : acqrs_pkg

// *** core/acqrs_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/10ps
module acqrs_pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Per bit so a glitch on one pin does not hold back another
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic bit_q;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					bit_q <= RST_VAL[i];
				end else if (s2_q[i] == s3_q[i]) begin
					bit_q <= s3_q[i];
				end
			end
			assign pin_out[i] = bit_q;
		end
	endgenerate
endmodule : acqrs_pin_sync

// *** tb/acqrs_spi_master.sv ***
// Serial port master model standing in for the microcontroller
`timescale 1ns/10ps
module acqrs_spi_master (
	input wire logic clk,
	input wire logic miso,
	output logic cs_n,
	output logic sclk,
	output logic mosi
);
	// Half period of the serial clock, 2 us at 200 MHz
	localparam int HALF = 400;
	logic pol_q = 1'b0;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic wait_half();
		repeat (HALF) @(negedge clk);
	endtask : wait_half
	// Idle level of sclk at the chip select fall sets the sampling edge
	task automatic start(input logic pol);
		@(negedge clk);
		pol_q = pol;
		sclk = pol;
		wait_half();
		cs_n = 1'b0;
		wait_half();
	endtask : start
	// Command and data bytes go MSB first; each bit is set on the edge leaving idle
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = ~pol_q;
			mosi = tx[i];
			wait_half();
			sclk = pol_q;
			rx[i] = miso;
			wait_half();
		end
	endtask : xfer
	// Released data line shows the inverse of its last value
	task automatic stop();
		wait_half();
		cs_n = 1'b1;
		mosi = ~mosi;
		wait_half();
	endtask : stop
endmodule : acqrs_spi_master

// *** tb/acqrs_top_tb.sv ***
// Self-checking bench for the result, status and current path control bank
`timescale 1ns/10ps
module acqrs_top_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] cur_result = 16'h0000;
	logic cur_valid = 1'b0;
	logic [15:0] volt_result = 16'h0000;
	logic volt_valid = 1'b0;
	logic [4:0] ev = 5'h00;
	logic tick = 1'b0;
	logic miso_last = 1'b0;
	logic cs_n, sclk, mosi, miso_o, miso_oe, miso_line, decim, sat_mask, chop;
	logic [1:0] chop_sel;
	logic [3:0] code;
	logic [15:0] ratio;
	logic [7:0] rx;
	int err_count = 0;
	int cmp_count = 0;
	always #2.5 clk = ~clk;
	always @(negedge clk) tick <= ~tick;
	always @(posedge clk) if (miso_oe) miso_last <= miso_o;
	assign miso_line = miso_oe ? miso_o : ~miso_last;
	acqrs_top DUT (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sclk(sclk),
		.spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
		.cur_result(cur_result), .cur_valid(cur_valid), .volt_result(volt_result),
		.volt_valid(volt_valid), .normal_measure_mode_one_ready(ev[4]),
		.normal_measure_mode_two_thresh(ev[3]), .standby_measure_mode_one_ready(ev[2]),
		.standby_measure_mode_two_thresh(ev[1]), .analog_power_on_reset_flag(ev[0]),
		.oversampling_tick(tick), .decim_rate_128(decim), .chop_div_sel(chop_sel),
		.cic2_ratio_code(code), .cic2_ratio(ratio), .sat_int_mask(sat_mask),
		.chopper_clock(chop));
	acqrs_spi_master m (.clk(clk), .miso(miso_line), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic conclude();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic t_reset();
		check("decim", 16'h0000, decim);
		check("chop_sel", 16'h0002, chop_sel);
		check("code", 16'h0002, code);
		check("ratio", 16'h0004, ratio);
		check("mask", 16'h0001, sat_mask);
	endtask : t_reset
	// A result update between the two bytes must not tear the pair
	task automatic t_burst_read();
		@(negedge clk);
		cur_result = 16'h1234;
		volt_result = 16'habcd;
		cur_valid = 1'b1;
		volt_valid = 1'b1;
		ev = 5'h1f;
		@(negedge clk);
		cur_valid = 1'b0;
		volt_valid = 1'b0;
		ev = 5'h00;
		m.start(1'b0);
		m.xfer(8'h80, rx);
		m.xfer(8'h00, rx);
		check("cur_hi", 16'h0012, rx);
		cur_result = 16'h5678;
		cur_valid = 1'b1;
		@(negedge clk);
		cur_valid = 1'b0;
		m.xfer(8'h00, rx);
		check("cur_lo", 16'h0034, rx);
		m.xfer(8'h00, rx);
		check("volt_hi", 16'h00ab, rx);
		m.xfer(8'h00, rx);
		check("volt_lo", 16'h00cd, rx);
		m.xfer(8'h00, rx);
		check("status", 16'h00fe, rx);
		m.stop();
	endtask : t_burst_read
	// Burst from the read-only status into control
	task automatic t_write();
		m.start(1'b0);
		m.xfer(8'h04, rx);
		m.xfer(8'hff, rx);
		m.xfer(8'h86, rx);
		m.stop();
		check("decim", 16'h0001, decim);
		check("chop_sel", 16'h0000, chop_sel);
		check("chop_high", 16'h0001, chop);
		check("code", 16'h0003, code);
		check("ratio", 16'h0008, ratio);
		check("mask", 16'h0000, sat_mask);
	endtask : t_write
	task automatic t_status_clear();
		m.start(1'b1);
		m.xfer(8'h84, rx);
		m.xfer(8'h00, rx);
		check("status_clr", 16'h0000, rx);
		m.xfer(8'h00, rx);
		check("ctrl_rd", 16'h0086, rx);
		m.stop();
	endtask : t_status_clear
	// Reset divide by 512 with a tick every second cycle gives 512-cycle halves
	task automatic t_chopper();
		logic c0;
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			@(negedge clk);
			c0 = chop;
			while (chop === c0 && n < 2000) begin
				@(negedge clk);
				n++;
			end
		end
		check("chop_half", 16'h01ff, n[15:0]);
	endtask : t_chopper
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_chopper();
		t_burst_read();
		t_write();
		t_status_clear();
		conclude();
	end
	// A clean run needs about 83k cycles; give up at 90k
	initial begin
		#450000;
		err_count++;
		conclude();
	end
endmodule : acqrs_top_tb
